// [logic/ivc_regs.vh]
// Address map, field positions, reset values and table geometry of the vector controller.
// Assumes inclusion by bare name from the design file; holds definitions only.
`ifndef IVC_REGS_VH
`define IVC_REGS_VH

// Register byte offsets on the AHB-Lite slave.
`define IVC_OFF_CTRL1        12'h000
`define IVC_OFF_CTRL2        12'h004
`define IVC_OFF_FLAGS0       12'h010
`define IVC_OFF_ENABLES0     12'h030
`define IVC_OFF_PRIO0        12'h050
`define IVC_OFF_CPU_LEVEL    12'h0a0
`define IVC_OFF_STATUS       12'h0a4
`define IVC_OFF_CAL          12'h0b0
`define IVC_OFF_FLASHCTL     12'h0b4
`define IVC_OFF_RESET_CAUSE  12'h0b8

// Field positions.
`define IVC_ALT_SEL_BIT      15
`define IVC_TRAP_LO_BIT      1
`define IVC_TRAP_HI_BIT      4
`define IVC_LEVEL_TOP_BIT    3

// Vector table geometry in program addresses.
`define IVC_PRIMARY_BASE     24'h000004
`define IVC_ALT_OFFSET       24'h000100
`define IVC_USER_BASE        24'h000014
`define IVC_RESET_ADDR       24'h000000
`define IVC_CODE_START       24'h000200
`define IVC_NUM_TRAPS        8
`define IVC_NUM_USER         118
`define IVC_NUM_FLAG_REGS    8

// Reset values.
`define IVC_RESET_CAUSE_POR  16'h0003
`define IVC_LEVEL_RESET      4'h0

// Entry and return latency in clock cycles, the same for every source.
`define IVC_ENTRY_CYCLES     4'h3
`define IVC_RETURN_CYCLES    4'h3

`endif

// [logic/ivc_controller.v]
// Interrupt vector controller: flags, enables, priorities, selection and vector address.
// Assumes an AHB-Lite master on one 20 MHz clock and a CPU core that takes one request.
// Overview of operation
// RULE1 - All request lines merge into one CPU request plus the chosen vector.
// RULE2 - Up to eight non-maskable traps, vectors ahead of user vectors.
// RULE3 - Seven selectable user priority levels; level zero never interrupts.
// RULE4 - Primary table starts at 000004h: eight traps then 118 user vectors.
// RULE5 - Each entry is a 24-bit service routine start address.
// RULE6 - Every source owns its own distinct vector entry.
// RULE7 - At equal priority the lower vector address wins; vector 0 outranks all.
// RULE8 - Entry and return latencies are fixed, independent of the source.
// RULE9 - Alternate select bit 15 of control two redirects every vector fetch.
// RULE10 - Alternate table lies 100h above the primary, same layout.
// RULE11 - Traps 1 to 4: oscillator, address, stack, math; 0, 5, 6, 7 reserved.
// RULE12 - User vector n sits at 000014h plus 2n; code starts at 000200h.
// RULE13 - Reset bypasses the controller; execution starts at 000000h.
// RULE14 - External inputs 0 to 4 use vectors 0, 20, 29, 53, 54.
// RULE15 - Timers one to five use vectors 3, 7, 8, 27, 28.
// RULE16 - Captures use 1, 5, 37, 38, 39; compares use 2, 6, 25, 26, 41.
// RULE17 - UART one uses 11, 12, 65; UART two uses 30, 31, 66.
// RULE18 - SPI vectors 9, 10, 32, 33; I2C vectors 16, 17, 49, 50.
// RULE19 - Converter 13, comparator 18, change 19, port 45, calendar 62, checksum 67.
// RULE20 - Flag and enable share bit position; priority fields are register nibbles.
// RULE21 - Reset values ignore reset cause except a few registers.
// RULE22 - Calibration and flash control registers reset only on power-on.
// RULE23 - Software fills unused vector entries with a resetting default handler.
// RULE24 - Software mirrors primary addresses into an unused alternate table.
// RULE25 - Flags set by their source and cleared only by software writes.
// RULE26 - Each user source has a 3-bit priority field in table order; the bus reaches only sources 0 to 79, others stay at 4.
// RULE27 - CPU level is 4 bits; 0111 blocks users, traps run above 7.
// RULE28 - Request only for flagged, enabled sources above CPU level; best wins.
// RULE29 - Pending traps beat user interrupts, lowest trap number first.
`timescale 1ns/1ps
`include "ivc_regs.vh"

module ivc_controller #(
    parameter NUM_USER = `IVC_NUM_USER
) (
    // Clock, system reset and power-on reset.
    input  wire                clk,
    input  wire                nrst,
    input  wire                por_nrst,
    // AHB-Lite slave.
    input  wire                hsel,
    input  wire [11:0]         haddr,
    input  wire [1:0]          htrans,
    input  wire                hwrite,
    input  wire [2:0]          hsize,
    input  wire [31:0]         hwdata,
    input  wire                hready,
    output reg  [31:0]         hrdata,
    output wire                hreadyout,
    output wire                hresp,
    // Request lines in vector order, and trap events.
    input  wire [NUM_USER-1:0] src_req,
    input  wire [7:0]          trap_req,
    // CPU core side.
    input  wire                cpu_ack,
    input  wire                cpu_return,
    input  wire [11:0]         vector_word_in,
    output reg                 irq,
    output reg  [6:0]          irq_vector,
    output reg                 irq_is_trap,
    output reg  [23:0]         vector_fetch_addr,
    output reg                 entry_done,
    output reg                 return_done
);

    // Flag and enable words, and priority words, on the bus.
    localparam [11:0] NREG  = `IVC_NUM_FLAG_REGS;
    localparam [11:0] NPRIO = 12'd20;

    // Sequencer states.
    localparam ST_IDLE   = 2'd0;
    localparam ST_ENTRY  = 2'd1;
    localparam ST_ACTIVE = 2'd2;
    localparam ST_RETURN = 2'd3;

    reg  [NUM_USER-1:0] flags_reg;
    reg  [NUM_USER-1:0] enables_reg;
    reg  [2:0]          prio_reg [0:NUM_USER-1];
    reg  [7:0]          trap_flags_reg;
    reg                 alt_sel_reg;
    reg  [3:0]          level_reg;
    reg  [15:0]         cal_reg;
    reg  [15:0]         flashctl_reg;
    reg  [15:0]         reset_cause_reg;
    reg  [1:0]          state_reg;
    reg  [3:0]          cnt_reg;
    reg  [3:0]          saved_level_reg;
    reg                 wr_pend_reg;
    reg  [11:0]         wr_addr_reg;
    reg                 rd_pend_reg;
    reg  [11:0]         rd_addr_reg;

    // Selects which of the 16-bit words of a long register an offset names.
    function [4:0] word_index;
        input [11:0] off;
        input [11:0] base;
        reg   [11:0] d;
        begin
            d = off - base;
            word_index = d[6:2];
        end
    endfunction

    // True when an offset lies in a block of words from base.
    function in_range;
        input [11:0] off;
        input [11:0] base;
        input [11:0] words;
        begin
            in_range = (off >= base) && (off < base + {words[9:0], 2'b00});
        end
    endfunction

    // A transfer is taken at its address phase edge.
    wire addr_ok = hsel && hready && htrans[1];

    // The slave never stalls and never errs.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
            rd_addr_reg <= 12'h000;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            rd_pend_reg <= addr_ok && !hwrite;
            wr_addr_reg <= haddr;
            rd_addr_reg <= haddr;
        end
    end

    // Selection: traps first, then highest priority above CPU level, lowest vector on tie.
    reg       sel_valid;
    reg       sel_trap;
    reg [6:0] sel_vec;
    reg [2:0] best_prio;
    integer   i;
    always @* begin
        sel_valid = 1'b0;
        sel_trap  = 1'b0;
        sel_vec   = 7'd0;
        best_prio = 3'd0;
        // Descending scan leaves the lowest trap number.
        for (i = 7; i >= 0; i = i - 1) begin
            if (trap_flags_reg[i]) begin                        // [RULE29] [RULE2]
                sel_valid = 1'b1;
                sel_trap  = 1'b1;
                sel_vec   = i[6:0];
            end
        end
        if (!sel_valid && !level_reg[`IVC_LEVEL_TOP_BIT]) begin // [RULE27]
            for (i = NUM_USER - 1; i >= 0; i = i - 1) begin
                // Descending loop with >= keeps the lowest vector on a tie.
                if (flags_reg[i] && enables_reg[i] && prio_reg[i] != 3'd0 // [RULE3]
                    && {1'b0, prio_reg[i]} > level_reg             // [RULE28]
                    && prio_reg[i] >= best_prio) begin             // [RULE7]
                    sel_valid = 1'b1;
                    sel_vec   = i[6:0];                            // [RULE6] [RULE19]
                    best_prio = prio_reg[i];
                end
            end
        end
    end

    // Program address of the selected entry; user vector n at base plus 2n.
    wire [23:0] tbl_base = alt_sel_reg ? `IVC_PRIMARY_BASE + `IVC_ALT_OFFSET  // [RULE9] [RULE10]
                                       : `IVC_PRIMARY_BASE;                  // [RULE4]
    wire [23:0] fetch_addr = sel_trap
        ? tbl_base + {16'h0000, sel_vec, 1'b0}                                // [RULE11]
        : tbl_base + (`IVC_USER_BASE - `IVC_PRIMARY_BASE)
          + {16'h0000, sel_vec, 1'b0};                                        // [RULE12]

    // Interrupt sequencer with fixed entry and return latency.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg         <= ST_IDLE;
            cnt_reg           <= 4'h0;
            irq               <= 1'b0;
            irq_vector        <= 7'd0;
            irq_is_trap       <= 1'b0;
            vector_fetch_addr <= `IVC_RESET_ADDR;                  // [RULE13]
            entry_done        <= 1'b0;
            return_done       <= 1'b0;
            saved_level_reg   <= `IVC_LEVEL_RESET;
        end else begin
            entry_done  <= 1'b0;
            return_done <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    irq <= sel_valid;                              // [RULE1]
                    if (sel_valid) begin
                        irq_vector        <= sel_vec;
                        irq_is_trap       <= sel_trap;
                        vector_fetch_addr <= fetch_addr;
                    end
                    if (irq && cpu_ack) begin
                        irq       <= 1'b0;
                        state_reg <= ST_ENTRY;
                        cnt_reg   <= `IVC_ENTRY_CYCLES;
                    end
                end
                // Same count for every source keeps entry fixed.
                ST_ENTRY: begin
                    cnt_reg <= cnt_reg - 4'h1;
                    if (cnt_reg == 4'h1) begin                     // [RULE8]
                        entry_done <= 1'b1;
                        state_reg  <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (cpu_return) begin
                        state_reg <= ST_RETURN;
                        cnt_reg   <= `IVC_RETURN_CYCLES;
                    end
                end
                // Same count for every source keeps return fixed.
                ST_RETURN: begin
                    cnt_reg <= cnt_reg - 4'h1;
                    if (cnt_reg == 4'h1) begin                     // [RULE8]
                        return_done <= 1'b1;
                        state_reg   <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
            // Level to restore when the routine returns.
            if (state_reg == ST_IDLE && irq && cpu_ack)
                saved_level_reg <= level_reg;
        end
    end

    // Flags: hardware set wins over a software clear in the same cycle.
    wire [4:0] wr_word = word_index(wr_addr_reg, `IVC_OFF_FLAGS0);
    wire [4:0] en_word = word_index(wr_addr_reg, `IVC_OFF_ENABLES0);
    wire [4:0] pr_word = word_index(wr_addr_reg, `IVC_OFF_PRIO0);
    wire wr_flags = wr_pend_reg && in_range(wr_addr_reg, `IVC_OFF_FLAGS0, NREG);
    wire wr_en    = wr_pend_reg && in_range(wr_addr_reg, `IVC_OFF_ENABLES0, NREG);
    wire wr_prio  = wr_pend_reg && in_range(wr_addr_reg, `IVC_OFF_PRIO0, NPRIO);

    // One slice per user source; index is the vector number.
    genvar g;
    generate
        for (g = 0; g < NUM_USER; g = g + 1) begin : gen_src
            always @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    flags_reg[g]   <= 1'b0;
                    enables_reg[g] <= 1'b0;
                    prio_reg[g]    <= 3'd4;
                end else begin
                    // Flag and enable share bit position g%16 of word g/16.
                    if (src_req[g])                                // [RULE25] [RULE14] [RULE15]
                        flags_reg[g] <= 1'b1;                      // [RULE16] [RULE17] [RULE18]
                    else if (wr_flags && wr_word == g / 16)
                        flags_reg[g] <= hwdata[g % 16];            // [RULE20]
                    if (wr_en && en_word == g / 16)
                        enables_reg[g] <= hwdata[g % 16];
                    if (wr_prio && pr_word == g / 4)
                        prio_reg[g] <= hwdata[(g % 4) * 4 +: 3];   // [RULE26]
                end
            end
        end
    endgenerate

    // Control, level and trap status registers.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            alt_sel_reg    <= 1'b0;
            level_reg      <= `IVC_LEVEL_RESET;                   // [RULE21]
            trap_flags_reg <= 8'h00;
        end else begin
            if (wr_pend_reg && wr_addr_reg == `IVC_OFF_CTRL2)
                alt_sel_reg <= hwdata[`IVC_ALT_SEL_BIT];
            // Level follows the source in service.
            if (state_reg == ST_ENTRY && cnt_reg == 4'h1)
                level_reg <= irq_is_trap ? 4'h8 : {1'b0, prio_reg[irq_vector]};
            else if (state_reg == ST_RETURN && cnt_reg == 4'h1)
                level_reg <= saved_level_reg;
            else if (wr_pend_reg && wr_addr_reg == `IVC_OFF_CPU_LEVEL)
                level_reg <= {level_reg[3], hwdata[2:0]};
            // Trap set wins over software clear; only implemented traps latch.
            if (wr_pend_reg && wr_addr_reg == `IVC_OFF_CTRL1)
                trap_flags_reg <= hwdata[7:0] | trap_req;
            else
                trap_flags_reg <= trap_flags_reg | trap_req;
            trap_flags_reg[0] <= 1'b0;                              // [RULE11]
            trap_flags_reg[7:5] <= 3'b000;
        end
    end

    // Registers touched only by power-on reset.
    always @(posedge clk or negedge por_nrst) begin
        if (!por_nrst) begin
            cal_reg         <= 16'h0000;                         // [RULE22]
            flashctl_reg    <= 16'h0000;
            reset_cause_reg <= `IVC_RESET_CAUSE_POR;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == `IVC_OFF_CAL)
                cal_reg <= hwdata[15:0];
            if (wr_addr_reg == `IVC_OFF_FLASHCTL)
                flashctl_reg <= hwdata[15:0];
            if (wr_addr_reg == `IVC_OFF_RESET_CAUSE)
                reset_cause_reg <= hwdata[15:0];
        end
    end

    // Read data path.
    reg [31:0] rd_val;
    reg [4:0]  rw;
    integer    k;
    always @* begin
        rd_val = 32'h0000_0000;
        rw     = 5'h00;
        if (in_range(rd_addr_reg, `IVC_OFF_FLAGS0, NREG)) begin
            rw = word_index(rd_addr_reg, `IVC_OFF_FLAGS0);
            for (k = 0; k < 16; k = k + 1)
                if (rw * 16 + k < NUM_USER)
                    rd_val[k] = flags_reg[rw * 16 + k];
        end else if (in_range(rd_addr_reg, `IVC_OFF_ENABLES0, NREG)) begin
            rw = word_index(rd_addr_reg, `IVC_OFF_ENABLES0);
            for (k = 0; k < 16; k = k + 1)
                if (rw * 16 + k < NUM_USER)
                    rd_val[k] = enables_reg[rw * 16 + k];
        end else if (in_range(rd_addr_reg, `IVC_OFF_PRIO0, NPRIO)) begin
            for (k = 0; k < 4; k = k + 1)
                if (((rd_addr_reg - `IVC_OFF_PRIO0) >> 2) * 4 + k < NUM_USER)
                    rd_val[k * 4 +: 3] =
                        prio_reg[((rd_addr_reg - `IVC_OFF_PRIO0) >> 2) * 4 + k];
        end else begin
            case (rd_addr_reg)
                `IVC_OFF_CTRL1:       rd_val = {24'h0, trap_flags_reg};
                `IVC_OFF_CTRL2:       rd_val = {16'h0, alt_sel_reg, 15'h0};
                `IVC_OFF_CPU_LEVEL:   rd_val = {28'h0, level_reg};
                `IVC_OFF_STATUS:      rd_val = {8'h0, vector_fetch_addr};  // [RULE5]
                `IVC_OFF_CAL:         rd_val = {16'h0, cal_reg};
                `IVC_OFF_FLASHCTL:    rd_val = {16'h0, flashctl_reg};
                `IVC_OFF_RESET_CAUSE: rd_val = {16'h0, reset_cause_reg};
                default:              rd_val = 32'h0000_0000;
            endcase
        end
    end

    // Read data stand only in the read data phase.
    always @* begin
        hrdata = rd_pend_reg ? rd_val : 32'h0000_0000;
    end

endmodule

// [verif/ivc_checker.sv]
// Port checker for the vector controller, bound onto ivc_controller.
// Assumes one clock domain and an AHB-Lite master writing whole words.
`timescale 1ns/1ps
module ivc_checker #(
    parameter NUM_USER = 118
) (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        nrst,
    // AHB-Lite address and data.
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    // CPU side.
    input wire logic        cpu_ack,
    input wire logic        cpu_return,
    input wire logic        irq,
    input wire logic [6:0]  irq_vector,
    input wire logic        irq_is_trap,
    input wire logic [23:0] vector_fetch_addr,
    input wire logic        entry_done,
    input wire logic        return_done
);
    logic        alt_reg;
    logic        ctl2_wr_reg;
    logic        svc_reg;
    logic [23:0] exp_addr;

    // Shadow of the alternate table select, taken from the bus writes.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            alt_reg     <= 1'b0;
            ctl2_wr_reg <= 1'b0;
            svc_reg     <= 1'b0;
        end else begin
            ctl2_wr_reg <= hsel && hready && htrans[1] && hwrite && haddr == 12'h004;
            if (ctl2_wr_reg && hready)
                alt_reg <= hwdata[15];
            if (entry_done)
                svc_reg <= 1'b1;
            else if (return_done)
                svc_reg <= 1'b0;
        end
    end

    assign exp_addr = (alt_reg ? 24'h000100 : 24'h000000)
                    + (irq_is_trap ? 24'h000004 : 24'h000014) + {16'h0000, irq_vector, 1'b0};

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_ack_drop: assert property (irq && cpu_ack |=> !irq)
        else $error("request stays up after acknowledge");
    chk_irq_holds: assert property (irq && !cpu_ack |=> irq && $stable(irq_vector))
        else $error("request or vector moved before acknowledge");
    chk_entry_lat: assert property (irq && cpu_ack |=> !entry_done [*3] ##1 entry_done)
        else $error("entry latency differs from the fixed count");
    chk_ret_lat: assert property (svc_reg && cpu_return |=> !return_done [*3] ##1 return_done)
        else $error("return latency differs from the fixed count");
    chk_entry_pulse: assert property (entry_done |=> !entry_done)
        else $error("entry pulse longer than one cycle");
    chk_vec_addr: assert property (irq |-> vector_fetch_addr == exp_addr)
        else $error("vector address does not match vector number");
    chk_trap_num: assert property (irq && irq_is_trap |-> irq_vector inside {[1:4]})
        else $error("reserved trap number requested");
    chk_user_num: assert property (irq && !irq_is_trap |-> irq_vector < NUM_USER)
        else $error("user vector out of table");
    chk_reset_idle: assert property ($rose(nrst) |-> !irq && vector_fetch_addr == 24'h0)
        else $error("request active out of reset");

    cover property (irq && irq_is_trap && cpu_ack);
    cover property (irq && alt_reg);
    cover property (svc_reg && return_done);
endmodule

bind ivc_controller ivc_checker #(.NUM_USER(NUM_USER)) i_chk (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .cpu_ack(cpu_ack), .cpu_return(cpu_return), .irq(irq),
    .irq_vector(irq_vector), .irq_is_trap(irq_is_trap), .vector_fetch_addr(vector_fetch_addr),
    .entry_done(entry_done), .return_done(return_done));

// [verif/ivc_cpu_model.sv]
// Behavioural CPU core that takes the single request, enters and leaves service.
// Assumes the bench sets the acknowledge wait and the service length.
`timescale 1ns/1ps
module ivc_cpu_model (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       nrst,
    // Pacing.
    input  wire logic [3:0] ack_wait,
    input  wire logic [7:0] svc_len,
    // Controller side.
    input  wire logic       irq,
    input  wire logic       entry_done,
    output logic            cpu_ack,
    output logic            cpu_return
);
    initial begin
        cpu_ack = 1'b0;
        cpu_return = 1'b0;
        forever begin
            @(posedge clk);
            if (nrst === 1'b1 && irq === 1'b1) begin
                repeat (ack_wait) @(posedge clk);
                cpu_ack <= 1'b1;
                @(posedge clk);
                cpu_ack <= 1'b0;
                while (entry_done !== 1'b1) @(posedge clk);
                repeat (svc_len) @(posedge clk);
                cpu_return <= 1'b1;
                @(posedge clk);
                cpu_return <= 1'b0;
            end
        end
    end
endmodule

// [verif/ivc_tb.sv]
// Self-checking bench for the vector controller with a CPU core model.
// Assumes zero wait state AHB-Lite answers and a 20 MHz clock.
`timescale 1ns/1ps
module tb;
    logic         clk, nrst, por_nrst, hsel, hwrite, hreadyout, hresp;
    logic         irq, irq_is_trap, entry_done, return_done, cpu_ack, cpu_return;
    logic [11:0]  haddr;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [31:0]  hwdata, hrdata, tmp;
    logic [117:0] src_req;
    logic [7:0]   trap_req, svc_len;
    logic [3:0]   ack_wait;
    logic [6:0]   irq_vector;
    logic [23:0]  vector_fetch_addr;
    wire logic    hready = hreadyout;
    int           error_cnt, checked, i;
    byte unsigned vecs[40] = '{0, 20, 29, 53, 54, 3, 7, 8, 27, 28, 1, 5, 37, 38, 39, 2, 6, 25,
        26, 41, 11, 12, 65, 30, 31, 66, 9, 10, 32, 33, 16, 17, 49, 50, 13, 18, 19, 45, 62, 67};

    ivc_controller #(.NUM_USER(118)) i_dut (
        .clk(clk), .nrst(nrst), .por_nrst(por_nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_req(src_req),
        .trap_req(trap_req), .cpu_ack(cpu_ack), .cpu_return(cpu_return),
        .vector_word_in(12'h000), .irq(irq), .irq_vector(irq_vector),
        .irq_is_trap(irq_is_trap), .vector_fetch_addr(vector_fetch_addr),
        .entry_done(entry_done), .return_done(return_done));

    ivc_cpu_model i_cpu (
        .clk(clk), .nrst(nrst), .ack_wait(ack_wait), .svc_len(svc_len), .irq(irq),
        .entry_done(entry_done), .cpu_ack(cpu_ack), .cpu_return(cpu_return));

    always #25 clk = ~clk;

    task automatic print_verdict();
        if (error_cnt == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, tmp);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, tmp);
        check(tmp, exp);
    endtask

    task automatic pulse(input logic [117:0] s, input logic [7:0] t);
        src_req  <= s;
        trap_req <= t;
        @(posedge clk);
        src_req  <= '0;
        trap_req <= '0;
        @(posedge clk);
    endtask

    task automatic quiet();
        repeat (8) @(posedge clk);
        check({31'h0, irq}, 32'h0);
    endtask

    // Waits for the request, checks it, clears the flag once in service, waits for return.
    task automatic serve(input logic [6:0] v, input logic t, input logic [23:0] ad,
                         input logic [11:0] co, input logic [31:0] cd);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        check({irq, irq_is_trap, irq_vector}, {1'b1, t, v});
        check({8'h00, vector_fetch_addr}, {8'h00, ad});
        n = 0;
        while (entry_done !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        check({31'h0, entry_done}, 32'h1);
        wr(co, cd);
        n = 0;
        while (return_done !== 1'b1 && n < 80) begin
            @(posedge clk);
            n++;
        end
        check({31'h0, return_done}, 32'h1);
    endtask

    initial begin
        #(50 * 20000);
        error_cnt++;
        print_verdict();
    end

    initial begin
        clk = 0; nrst = 0; por_nrst = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
        hsize = 3'b010; hwdata = 0; src_req = 0; trap_req = 0; ack_wait = 0; svc_len = 12;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        por_nrst <= 1'b1;
        @(posedge clk);
        rd_chk(12'h050, 32'h4444);
        rd_chk(12'h0b8, 32'h0003);
        rd_chk(12'h0a0, 32'h0);
        rd_chk(12'h800, 32'h0);
        pulse(118'd1 << 13, 8'h00);
        quiet();
        rd_chk(12'h010, 32'h2000);
        wr(12'h010, 32'h0);
        rd_chk(12'h010, 32'h0);
        for (i = 0; i < 8; i++)
            wr(12'(48 + 4 * i), 32'hffff);
        foreach (vecs[i]) begin
            pulse(118'd1 << vecs[i], 8'h00);
            serve(7'(vecs[i]), 1'b0, 24'(20 + 2 * vecs[i]), 12'(16 + 4 * (vecs[i] / 16)),
                  32'h0);
        end
        pulse((118'd1 << 2) | (118'd1 << 5), 8'h00);
        serve(7'd2, 1'b0, 24'h18, 12'h010, 32'h20);
        serve(7'd5, 1'b0, 24'h1e, 12'h010, 32'h0);
        wr(12'h054, 32'h4464);
        pulse((118'd1 << 2) | (118'd1 << 5), 8'h00);
        serve(7'd5, 1'b0, 24'h1e, 12'h010, 32'h4);
        serve(7'd2, 1'b0, 24'h18, 12'h010, 32'h0);
        wr(12'h054, 32'h4404);
        pulse(118'd1 << 5, 8'h00);
        quiet();
        wr(12'h010, 32'h0);
        wr(12'h054, 32'h4444);
        wr(12'h0a0, 32'h7);
        rd_chk(12'h0a0, 32'h7);
        ack_wait <= 4'd5;
        pulse(118'd1, 8'h08);
        serve(7'd3, 1'b1, 24'h0a, 12'h000, 32'h0);
        quiet();
        wr(12'h0a0, 32'h0);
        serve(7'd0, 1'b0, 24'h14, 12'h010, 32'h0);
        for (i = 1; i < 5; i++) begin
            pulse(118'd0, 8'(1 << i));
            serve(7'(i), 1'b1, 24'(4 + 2 * i), 12'h000, 32'h0);
        end
        pulse(118'd0, 8'he1);
        quiet();
        ack_wait <= 4'd0;
        wr(12'h004, 32'h8000);
        pulse(118'd1 << 54, 8'h00);
        serve(7'd54, 1'b0, 24'h180, 12'h01c, 32'h0);
        pulse(118'd0, 8'h02);
        serve(7'd1, 1'b1, 24'h106, 12'h000, 32'h0);
        rd_chk(12'h0a4, 32'h106);
        wr(12'h004, 32'h0);
        wr(12'h0b0, 32'h1234);
        wr(12'h050, 32'h1111);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rd_chk(12'h0b0, 32'h1234);
        rd_chk(12'h050, 32'h4444);
        nrst <= 1'b0;
        por_nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        por_nrst <= 1'b1;
        @(posedge clk);
        rd_chk(12'h0b0, 32'h0);
        print_verdict();
    end
endmodule
